// ---- include/pipp_pkg.sv ----
// Package of constants for the port pending-flag and pull-up block
package pipp_pkg;

  // ****************************************
  // Register map
  // ****************************************
  // Register indices; the byte address is four times the index
  localparam logic [7:0] PEND_IDX = 8'he6;
  localparam logic [7:0] PULL_IDX = 8'hee;
  localparam int ADDR_LSB = 2;
  localparam int IDX_W = 8;
  localparam int MAP_TOP = ADDR_LSB + IDX_W;

  // ****************************************
  // Reset values and bus codes
  // ****************************************
  localparam logic [7:0] PEND_RESET = 8'h00;
  localparam logic [7:0] PULL_RESET = 8'h00;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic OKAY = 1'b0;
  localparam int NUM_PINS = 8;
  localparam int UPPER_LSB = 4;

  // Address decode shared by reads and writes
  function automatic logic hit(input logic [7:0] idx, input logic [7:0] reg_idx);
    hit = (idx == reg_idx);
  endfunction

endpackage

// ---- rtl/pipp_ahb_slave.sv ----
// AHB-Lite address-phase capture for the port pending-flag block
`timescale 1ns/10ps
module pipp_ahb_slave (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Address phase
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  // Register access
  output logic rd_en,
  output logic [7:0] rd_idx,
  output logic wr_q,
  output logic [7:0] wr_idx_q
);

  logic take;
  logic mapped;

  // A legal word transfer in a mapped window
  always_comb begin
    take = hsel && htrans[1] && hready;
    mapped = (haddr[31:pipp_pkg::MAP_TOP] == '0) &&
             (haddr[pipp_pkg::ADDR_LSB-1:0] == '0) &&
             (hsize == pipp_pkg::HSIZE_WORD);
    rd_en = take && mapped && !hwrite;
    rd_idx = haddr[pipp_pkg::MAP_TOP-1:pipp_pkg::ADDR_LSB];
  end

  // Hold a write over to its data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      wr_idx_q <= 8'h00;
    end else begin
      wr_q <= take && mapped && hwrite;
      if (take) begin
        wr_idx_q <= haddr[pipp_pkg::MAP_TOP-1:pipp_pkg::ADDR_LSB];
      end
    end
  end

endmodule

// ---- rtl/pipp_port2_irq_pending_pullup.sv ----
// Port pending flags and pull-up enables behind an AHB-Lite slave
`timescale 1ns/10ps
module pipp_port2_irq_pending_pullup #(
  parameter int PINS = pipp_pkg::NUM_PINS
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // From the enable register and the edge detectors
  input wire logic [PINS-1:0] irq_enable,
  input wire logic [PINS-1:0] trigger_detect,
  // Interrupt source requests
  output logic ext_irq_source_pin0,
  output logic ext_irq_source_pin1,
  output logic ext_irq_source_pin2,
  output logic ext_irq_source_pin3,
  output logic ext_irq_source_upper_pins,
  // Pin pad controls
  output logic [PINS-1:0] port_pullup_enables
);

  // ****************************************
  // Declarations
  // ****************************************
  logic rd_en;
  logic [7:0] rd_idx;
  logic wr_q;
  logic [7:0] wr_idx_q;
  logic wr_pend;
  logic wr_pull;
  logic [PINS-1:0] hw_set;
  logic [PINS-1:0] pend_q;
  logic [PINS-1:0] pend_d;
  logic [PINS-1:0] pull_q;
  logic [PINS-1:0] pull_d;
  logic [31:0] rdata_d;
  logic [3:0] src_pin_q;
  logic src_upper_q;
  logic rd_pend_q;
  logic rd_pull_q;

  // ****************************************
  // Bus front end
  // ****************************************
  pipp_ahb_slave u_slave (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hready(hready),
    .rd_en(rd_en),
    .rd_idx(rd_idx),
    .wr_q(wr_q),
    .wr_idx_q(wr_idx_q)
  );

  // Data-phase write strobes
  assign wr_pend = wr_q && pipp_pkg::hit(wr_idx_q, pipp_pkg::PEND_IDX);
  assign wr_pull = wr_q && pipp_pkg::hit(wr_idx_q, pipp_pkg::PULL_IDX);

  // ****************************************
  // Pending flags
  // ****************************************
  // Trigger on an enabled pin
  assign hw_set = trigger_detect & irq_enable;

  // Zero clears, one keeps, hardware set wins over the clear
  always_comb begin
    pend_d = pend_q;
    if (wr_pend) begin
      pend_d = pend_q & hwdata[PINS-1:0];
    end
    pend_d = pend_d | hw_set;
  end

  // Flag storage
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend_q <= pipp_pkg::PEND_RESET;
    end else begin
      pend_q <= pend_d;
    end
  end

  // Source requests follow the flags in step with them
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      src_pin_q <= 4'h0;
      src_upper_q <= 1'b0;
    end else begin
      src_pin_q <= pend_d[pipp_pkg::UPPER_LSB-1:0];
      src_upper_q <= |pend_d[PINS-1:pipp_pkg::UPPER_LSB];
    end
  end

  assign ext_irq_source_pin0 = src_pin_q[0];
  assign ext_irq_source_pin1 = src_pin_q[1];
  assign ext_irq_source_pin2 = src_pin_q[2];
  assign ext_irq_source_pin3 = src_pin_q[3];
  assign ext_irq_source_upper_pins = src_upper_q;

  // ****************************************
  // Pull-up enables
  // ****************************************
  // Write takes the whole byte
  always_comb begin
    pull_d = pull_q;
    if (wr_pull) begin
      pull_d = hwdata[PINS-1:0];
    end
  end

  // Pull-up storage drives the pads directly
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pull_q <= pipp_pkg::PULL_RESET;
    end else begin
      pull_q <= pull_d;
    end
  end

  assign port_pullup_enables = pull_q;

  // ****************************************
  // Read data and response
  // ****************************************
  // Next values are read so a write just before is seen
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (pipp_pkg::hit(rd_idx, pipp_pkg::PEND_IDX)) begin
      rdata_d[PINS-1:0] = pend_d;
    end else if (pipp_pkg::hit(rd_idx, pipp_pkg::PULL_IDX)) begin
      rdata_d[PINS-1:0] = pull_d;
    end
  end

  // Load read data for the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
      rd_pend_q <= 1'b0;
      rd_pull_q <= 1'b0;
    end else begin
      rd_pend_q <= rd_en && pipp_pkg::hit(rd_idx, pipp_pkg::PEND_IDX);
      rd_pull_q <= rd_en && pipp_pkg::hit(rd_idx, pipp_pkg::PULL_IDX);
      if (rd_en) begin
        hrdata <= rdata_d;
      end
    end
  end

  // Zero-wait slave, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= pipp_pkg::OKAY;
    end else begin
      hreadyout <= 1'b1;
      hresp <= pipp_pkg::OKAY;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_clear_zero;
    wr_pend |=> ((pend_q & ~$past(hwdata[7:0]) & ~$past(hw_set)) == 8'h00);
  endproperty
  a_clear_zero: assert property (p_clear_zero)
    else $error("pending flag not cleared by a zero write");

  property p_one_keeps;
    wr_pend |=> ((pend_q & $past(hwdata[7:0])) ==
                 (($past(pend_q) | $past(hw_set)) & $past(hwdata[7:0])));
  endproperty
  a_one_keeps: assert property (p_one_keeps)
    else $error("writing one changed a pending flag");

  property p_low_sources;
    ##1 ({ext_irq_source_pin3, ext_irq_source_pin2, ext_irq_source_pin1,
           ext_irq_source_pin0} == pend_q[3:0]);
  endproperty
  a_low_sources: assert property (p_low_sources)
    else $error("lower source requests differ from flags");

  property p_read_pend;
    rd_en && pipp_pkg::hit(rd_idx, pipp_pkg::PEND_IDX) |=>
      (hrdata == {24'h000000, pend_q}) && hreadyout;
  endproperty
  a_read_pend: assert property (p_read_pend)
    else $error("pending read returned wrong flags");

  property p_pull_write;
    wr_pull |=> (port_pullup_enables == $past(hwdata[7:0])) ##1
                (port_pullup_enables == pull_q);
  endproperty
  a_pull_write: assert property (p_pull_write)
    else $error("pull-up enables did not take the written byte");

  property p_pull_read;
    rd_pull_q |-> (hrdata[7:0] == port_pullup_enables) && (hrdata[31:8] == 24'h000000);
  endproperty
  a_pull_read: assert property (p_pull_read)
    else $error("pull-up read returned wrong value");

  property p_upper_source;
    $rose(|pend_q[7:4]) |-> ext_irq_source_upper_pins ##1
      ((|pend_q[7:4]) == ext_irq_source_upper_pins);
  endproperty
  a_upper_source: assert property (p_upper_source)
    else $error("upper source request does not follow flags 7 to 4");

  property p_hw_set;
    (|hw_set) |=> ((pend_q & $past(hw_set)) == $past(hw_set)) && (hresp == pipp_pkg::OKAY);
  endproperty
  a_hw_set: assert property (p_hw_set)
    else $error("enabled trigger did not set its pending flag");

  // Guards on flag storage, source requests, pull-up enables and the bus data phase
  property p_pend_read_upper;
    rd_pend_q |-> (hrdata[31:8] == 24'h000000) && (hrdata[7:0] == pend_q) && hreadyout;
  endproperty
  a_pend_read_upper: assert property (p_pend_read_upper)
    else $error("pending read data phase carries wrong value");

  property p_pend_hold;
    (!wr_pend && !(|hw_set)) |=> $stable(pend_q);
  endproperty
  a_pend_hold: assert property (p_pend_hold)
    else $error("pending flags changed with no write and no trigger");

  property p_no_soft_set;
    1'b1 |=> ((pend_q & ~$past(pend_q) & ~$past(hw_set)) == '0);
  endproperty
  a_no_soft_set: assert property (p_no_soft_set)
    else $error("pending flag set without an enabled trigger");

  property p_flag_stays;
    !wr_pend |=> ((pend_q & $past(pend_q)) == $past(pend_q));
  endproperty
  a_flag_stays: assert property (p_flag_stays)
    else $error("pending flag dropped without a zero write");

  property p_mid_sources;
    (pend_q[5] || pend_q[4]) |-> ext_irq_source_upper_pins;
  endproperty
  a_mid_sources: assert property (p_mid_sources)
    else $error("flag 5 or 4 set but upper source request low");

  property p_top_sources;
    (pend_q[7] || pend_q[6]) |-> ext_irq_source_upper_pins;
  endproperty
  a_top_sources: assert property (p_top_sources)
    else $error("flag 7 or 6 set but upper source request low");

  property p_upper_idle;
    (pend_q[7:4] == 4'h0) |-> !ext_irq_source_upper_pins;
  endproperty
  a_upper_idle: assert property (p_upper_idle)
    else $error("upper source request high with flags 7 to 4 clear");

  property p_low_set_source;
    (|hw_set[3:0]) |=> (({ext_irq_source_pin3, ext_irq_source_pin2, ext_irq_source_pin1,
                          ext_irq_source_pin0} & $past(hw_set[3:0])) == $past(hw_set[3:0]));
  endproperty
  a_low_set_source: assert property (p_low_set_source)
    else $error("lower source request missing after a trigger");

  property p_upper_set_source;
    (|hw_set[7:4]) |=> ext_irq_source_upper_pins;
  endproperty
  a_upper_set_source: assert property (p_upper_set_source)
    else $error("upper source request missing after a trigger");

  property p_pull_hold;
    !wr_pull |=> $stable(port_pullup_enables);
  endproperty
  a_pull_hold: assert property (p_pull_hold)
    else $error("pull-up enables changed without a write");

  property p_hrdata_hold;
    !rd_en |=> $stable(hrdata);
  endproperty
  a_hrdata_hold: assert property (p_hrdata_hold)
    else $error("read data changed without a read");

  property p_bus_okay;
    1'b1 |-> hreadyout && (hresp == pipp_pkg::OKAY);
  endproperty
  a_bus_okay: assert property (p_bus_okay)
    else $error("slave inserted a wait or an error response");

endmodule

// ---- tb/tb.sv ----
// Self-checking testbench for the port pending-flag and pull-up block
`timescale 1ns/10ps
module tb;
  // ****************************************
  // Signals and expectation state
  // ****************************************
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rv;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] irq_enable, trigger_detect, port_pullup_enables, pend_m, pull_m, d, t;
  wire [4:0] srcs;
  int n_errors, n_checks, seed;
  localparam logic [31:0] PEND_A = {22'h0, pipp_pkg::PEND_IDX, 2'h0};
  localparam logic [31:0] PULL_A = {22'h0, pipp_pkg::PULL_IDX, 2'h0};

  // Single slave, so its ready is the bus ready
  assign hready = hreadyout;

  pipp_port2_irq_pending_pullup #(.PINS(8)) u_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .irq_enable(irq_enable),
    .trigger_detect(trigger_detect), .ext_irq_source_pin0(srcs[0]),
    .ext_irq_source_pin1(srcs[1]), .ext_irq_source_pin2(srcs[2]),
    .ext_irq_source_pin3(srcs[3]), .ext_irq_source_upper_pins(srcs[4]),
    .port_pullup_enables(port_pullup_enables)
  );

  // 20 MHz clock
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  // ****************************************
  // Tasks and functions
  // ****************************************
  // Flags after a write: zero bits clear, ones keep, hardware sets win
  function automatic logic [7:0] exp_pend(input logic [7:0] old, input logic [7:0] wd,
                                          input logic [7:0] set);
    exp_pend = (old & wd) | set;
  endfunction

  task report_and_stop;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  // Bounded wait for hready high at a rising edge
  task hs;
    int i;
    for (i = 0; i < 20; i++) begin
      @(posedge hclk);
      if (hready === 1'b1) break;
    end
    if (i == 20) begin
      n_errors++;
      $display("unexpected at %0t: bus never ready", $time);
      report_and_stop;
    end
  endtask

  task addr_ph(input logic [31:0] a, input logic w);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    hsize <= pipp_pkg::HSIZE_WORD;
    hs;
    hsel <= 1'b0;
    htrans <= 2'h0;
  endtask

  // Write with an optional trigger in the same data phase
  task wr(input logic [31:0] a, input logic [7:0] wd, input logic [7:0] tr);
    addr_ph(a, 1'b1);
    hwdata <= {24'h0, wd};
    trigger_detect <= tr;
    hs;
    trigger_detect <= 8'h0;
  endtask

  task rd(input logic [31:0] a, output logic [31:0] v);
    addr_ph(a, 1'b0);
    hs;
    v = hrdata;
    chk({31'h0, hresp}, {31'h0, pipp_pkg::OKAY});
  endtask

  task trig(input logic [7:0] e, input logic [7:0] tr);
    irq_enable <= e;
    trigger_detect <= tr;
    @(posedge hclk);
    trigger_detect <= 8'h0;
    pend_m = pend_m | (e & tr);
  endtask

  // Pin-side outputs compared mid-cycle, then realigned to a rising edge
  task check_out;
    @(negedge hclk);
    chk({27'h0, srcs}, {27'h0, |pend_m[7:4], pend_m[3:0]});
    chk({24'h0, port_pullup_enables}, {24'h0, pull_m});
    @(posedge hclk);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    seed = 93;
    n_errors = 0;
    n_checks = 0;
    {hresetn, hsel, hwrite, haddr, htrans, hwdata} = '0;
    hsize = 3'h2;
    {irq_enable, trigger_detect, pend_m, pull_m} = '0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    rd(PEND_A, rv);
    chk(rv, 32'h0);
    rd(PULL_A, rv);
    chk(rv, 32'h0);
    check_out;
    // Corners: every pin set, then an all-ones write keeps every flag
    trig(8'hff, 8'hff);
    check_out;
    wr(PEND_A, 8'hff, 8'h00);
    rd(PEND_A, rv);
    chk(rv, {24'h0, pend_m});
    for (int i = 0; i < 24; i++) begin
      d = 8'($random(seed));
      wr(PULL_A, d, 8'h00);
      pull_m = d;
      rd(PULL_A, rv);
      chk(rv, {24'h0, pull_m});
      trig(8'($random(seed)), 8'($random(seed)));
      check_out;
      d = (i % 4 == 0) ? 8'h00 : 8'($random(seed));
      t = i[0] ? 8'($random(seed)) : 8'h00;
      pend_m = exp_pend(pend_m, d, t & irq_enable);
      wr(PEND_A, d, t);
      rd(PEND_A, rv);
      chk(rv, {24'h0, pend_m});
      check_out;
    end
    // Unmapped and misaligned accesses change nothing; the unmapped read gives zero, the misaligned one keeps that last read data
    wr(PULL_A + 32'h4, 8'h5a, 8'h00);
    wr(PULL_A + 32'h1, 8'ha5, 8'h00);
    rd(PULL_A + 32'h4, rv);
    chk(rv, 32'h0);
    rd(PEND_A + 32'h1, rv);
    chk(rv, 32'h0);
    rd(PULL_A, rv);
    chk(rv, {24'h0, pull_m});
    // Second reset in mid run
    hresetn <= 1'b0;
    @(posedge hclk);
    hresetn <= 1'b1;
    pend_m = 8'h00;
    pull_m = 8'h00;
    check_out;
    rd(PEND_A, rv);
    chk(rv, 32'h0);
    rd(PULL_A, rv);
    chk(rv, 32'h0);
    report_and_stop;
  end
endmodule
